// ---- cld_chk.sv ----
// Port-level assertions for the configuration loader block
`timescale 1ns/1ps
`default_nettype none
module cld_chk
	import cld_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic usb_bus_reset,
	input wire logic usb_suspend,
	input wire logic usb_wake_signal,
	input wire logic [15:0] usb_version,
	input wire logic power_enable_n,
	input wire logic [1:0] config_io_pins_oe,
	input wire logic fifo_pulldown_oe
);
	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_pd_asleep: assert property (fifo_pulldown_oe |-> power_enable_n && usb_suspend)
		else $error("pull-down outside suspend");
	a_pe_on_suspend: assert property (usb_suspend |-> power_enable_n)
		else $error("power enable active in suspend");
	a_float_release: assert property (
		$rose(arst_n) |-> config_io_pins_oe == 2'b00 && !fifo_pulldown_oe)
		else $error("pins driven at reset release");
	a_float_reload: assert property (
		usb_bus_reset ##1 usb_bus_reset |-> config_io_pins_oe == 2'b00 && !fifo_pulldown_oe)
		else $error("pins driven during reload");
	a_ver_reset: assert property ($rose(arst_n) |-> usb_version == CLD_USBVER_RST)
		else $error("version not default");
	a_wake_hold: assert property ($rose(usb_wake_signal) |=> usb_wake_signal[*8])
		else $error("wake signal cut short");
	a_wake_asleep: assert property ($rose(usb_wake_signal) |-> power_enable_n)
		else $error("wake while awake");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	c_pd: cover property (fifo_pulldown_oe);
	c_wake: cover property ($rose(usb_wake_signal));
	c_reload: cover property ($fell(usb_bus_reset));
endmodule
bind cld_top cld_chk cld_chk_inst (.clk(clk), .arst_n(arst_n), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.usb_bus_reset(usb_bus_reset), .usb_suspend(usb_suspend), .usb_wake_signal(usb_wake_signal),
	.usb_version(usb_version), .power_enable_n(power_enable_n),
	.config_io_pins_oe(config_io_pins_oe), .fifo_pulldown_oe(fifo_pulldown_oe));
`default_nettype wire

// ---- cld_host_mdl.sv ----
// Behavioural model of the USB host or charging port facing the block
`timescale 1ns/1ps
`default_nettype none
module cld_host_mdl (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [1:0] mode,
	input wire logic bus_rst_req,
	output logic usb_suspend,
	output logic usb_lines_shorted,
	output logic usb_bus_reset
);
	// ****************************************
	// Port state: 0 enumerated host, 1 host asleep, 2 charging port
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			usb_suspend <= 1'b0;
			usb_lines_shorted <= 1'b0;
			usb_bus_reset <= 1'b0;
		end else begin
			// An enumerated host keeps the bus active, so no suspend
			usb_suspend <= (mode != 2'd0);
			// A charging port ties the data lines together
			usb_lines_shorted <= (mode == 2'd2);
			usb_bus_reset <= bus_rst_req;
		end
	end
endmodule
`default_nettype wire

// ---- cld_pkg.sv ----
// Package of constants and types for the configuration loader and charger detect block
package cld_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] CLD_CTRL_OFF = 8'h00; // Control: reload request in bit 0
	localparam logic [7:0] CLD_STAT_OFF = 8'h04; // Live status
	localparam logic [7:0] CLD_IRQ_STAT_OFF = 8'h08; // Sticky event bits, read only
	localparam logic [7:0] CLD_IRQ_CLR_OFF = 8'h0c; // Write one to clear, write only
	localparam logic [7:0] CLD_IRQ_EN_OFF = 8'h10; // Interrupt enable
	localparam logic [7:0] CLD_IMG_ADDR_OFF = 8'h14; // Config memory write address
	localparam logic [7:0] CLD_IMG_DATA_OFF = 8'h18; // Config memory write data

	// ****************************************
	// Config image layout (word index in rewritable memory)
	// ****************************************
	localparam int CLD_IMG_WORDS = 8; // Words scanned on each load
	localparam logic [2:0] CLD_W_OPTS = 3'h0; // Option bits word
	localparam logic [2:0] CLD_W_PIN5 = 3'h1; // Function of config pin five
	localparam logic [2:0] CLD_W_PIN6 = 3'h2; // Function of config pin six
	localparam logic [2:0] CLD_W_USBVER = 3'h3; // USB version field (BCD)
	localparam int CLD_OPT_PD_BIT = 0; // Pull-down on suspend
	localparam int CLD_OPT_WAKE_BIT = 1; // Remote wake enable

	// ****************************************
	// Reset / default image values
	// ****************************************
	localparam logic [31:0] CLD_OPTS_RST = 32'h0000_0000; // Pull-down and wake off
	localparam logic [15:0] CLD_USBVER_RST = 16'h0200; // Reported as USB 2.0
	localparam logic [31:0] CLD_SPEED_BPS = 32'd12000000; // Full speed only

	// Functions selectable on a config pin
	localparam logic [2:0] CLD_FN_TRISTATE = 3'h0; // Pin unused, high impedance
	localparam logic [2:0] CLD_FN_HOST_SENSE = 3'h1; // Host power sense input
	localparam logic [2:0] CLD_FN_STAY_AWAKE = 3'h2; // Stay-awake input, active low
	localparam logic [2:0] CLD_FN_CHG = 3'h3; // Charger detect, active high
	localparam logic [2:0] CLD_FN_CHG_N = 3'h4; // Charger detect, active low
	localparam logic [2:0] CLD_FN_PIN5_RST = CLD_FN_HOST_SENSE;
	localparam logic [2:0] CLD_FN_PIN6_RST = CLD_FN_STAY_AWAKE;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLD_CLK_MHZ = 200; // System clock rate
	localparam int CLD_WAKE_MS = 20; // Remote wake signalling time
	// Milliseconds times MHz times 1000 gives cycles; this order keeps the product in int range
	localparam int CLD_WAKE_CYC = CLD_WAKE_MS * CLD_CLK_MHZ * 1000;

	// Interrupt bits
	localparam int CLD_IRQ_LOAD = 0; // Load finished
	localparam int CLD_IRQ_CHG = 1; // Charging port detected
	localparam int CLD_IRQ_WAKE = 2; // Remote wake sent
	localparam int CLD_IRQ_W = 3;

	// Loader states, one-hot
	typedef enum logic [2:0] {
		CLD_S_IDLE = 3'b001,
		CLD_S_SCAN = 3'b010,
		CLD_S_DONE = 3'b100
	} cld_state_t;

	// Decode of a pin function: true for either of its two charger polarities
	function automatic logic cld_is_chg(input logic [2:0] fn);
		return (fn == CLD_FN_CHG) || (fn == CLD_FN_CHG_N);
	endfunction

endpackage

// ---- cld_sync.sv ----
// Two flip-flop level synchroniser, vector wide
`timescale 1ns/1ps
`default_nettype none
module cld_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [W-1:0] s1; // First stage, read only by s2
		logic [W-1:0] s2; // Second stage
	} cld_sync_t;
	cld_sync_t st_reg, st_next;

	// Shift one stage per clock
	always_comb begin
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	// Reset to the idle level of the pins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= {RST, RST};
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;
endmodule
`default_nettype wire

// ---- cld_top.sv ----
// Configuration loader, config pin mux and charger detect with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module cld_top
	import cld_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// USB side signals to and from the core
	input wire logic usb_bus_reset,
	input wire logic usb_suspend,
	input wire logic usb_lines_shorted,
	output logic usb_wake_signal,
	output logic usb_stay_awake,
	output logic usb_host_power,
	output logic [15:0] usb_version,
	// Pins
	input wire logic wake_request_n,
	output logic power_enable_n,
	input wire logic [1:0] config_io_pins_in,
	output logic [1:0] config_io_pins_out,
	output logic [1:0] config_io_pins_oe,
	output logic fifo_pulldown_oe,
	output logic irq
);
	// ****************************************
	// Synchronised pins
	// ****************************************
	logic [1:0] pins_sync; // Config pins after two flops
	logic wake_n_sync; // Wake request after two flops

	cld_sync #(.W(3), .RST(3'b111)) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d({wake_request_n, config_io_pins_in}),
		.q({wake_n_sync, pins_sync})
	);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		cld_state_t state; // Loader state
		logic [2:0] scan_idx; // Image word being loaded
		logic [31:0] opts; // Loaded option bits
		logic [2:0] fn5; // Loaded pin five function
		logic [2:0] fn6; // Loaded pin six function
		logic [15:0] usbver; // Loaded version field
		logic loaded; // Image is live
		logic reload_req; // Software reload pending
		logic [2:0] wr_addr; // Memory write pointer
		logic aw_held; // Write address taken
		logic w_held; // Write data taken
		logic [7:0] aw_addr; // Captured write address
		logic [31:0] w_data; // Captured write data
		logic bvalid; // Write response pending
		logic [1:0] bresp; // Write response code
		logic rvalid; // Read data pending
		logic [1:0] rresp; // Read response code
		logic [31:0] rdata; // Read data
		logic [CLD_IRQ_W-1:0] irq_stat; // Sticky events
		logic [CLD_IRQ_W-1:0] irq_en; // Interrupt enables
		logic [31:0] wake_cnt; // Remote wake timer
		logic wake_on; // Wake signalling active
		logic chg_prev; // Charger detect last cycle
	} cld_st_t;
	cld_st_t st_reg, st_next;

	// Rewritable config memory, kept outside the struct to stay a RAM
	logic [31:0] cfg_mem [CLD_IMG_WORDS];
	logic mem_we; // Write strobe into the memory
	logic [31:0] mem_rd; // Word at the scan index

	// Memory preloaded with the factory image at power-on
	// Plain always, since the preload below also writes this array and always_ff forbids that
	always @(posedge clk) begin
		if (mem_we) begin
			cfg_mem[st_reg.wr_addr] <= st_reg.w_data;
		end
	end
	initial begin
		for (int i = 0; i < CLD_IMG_WORDS; i++) begin
			cfg_mem[i] = 32'h0000_0000;
		end
		cfg_mem[CLD_W_OPTS] = CLD_OPTS_RST;
		cfg_mem[CLD_W_PIN5] = {29'h0, CLD_FN_PIN5_RST};
		cfg_mem[CLD_W_PIN6] = {29'h0, CLD_FN_PIN6_RST};
		cfg_mem[CLD_W_USBVER] = {16'h0, CLD_USBVER_RST};
	end
	assign mem_rd = cfg_mem[st_reg.scan_idx];

	// ****************************************
	// Derived conditions
	// ****************************************
	logic chg_det; // Charging port found while suspended
	logic suspended; // Device in suspend
	logic aw_fire, w_fire, ar_fire;
	logic wr_go; // Both write halves present

	// Only suspended + shorted lines counts, so an enumerated device never flags
	assign chg_det = usb_suspend && usb_lines_shorted && st_reg.loaded;
	assign suspended = usb_suspend;
	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;
	assign ar_fire = s_axi_arvalid && s_axi_arready;
	assign wr_go = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
	assign mem_we = wr_go && (st_reg.aw_addr == CLD_IMG_DATA_OFF);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [CLD_IRQ_W-1:0] ev;
		ev = '0;
		st_next = st_reg;

		// Loader: scan every image word, restart on any bus reset
		case (st_reg.state)
			CLD_S_IDLE: begin
				st_next.scan_idx = 3'h0;
				st_next.state = CLD_S_SCAN;
				st_next.loaded = 1'b0;
			end
			CLD_S_SCAN: begin
				case (st_reg.scan_idx)
					CLD_W_OPTS: st_next.opts = mem_rd;
					CLD_W_PIN5: st_next.fn5 = mem_rd[2:0];
					CLD_W_PIN6: st_next.fn6 = mem_rd[2:0];
					CLD_W_USBVER: st_next.usbver = mem_rd[15:0];
					default: ;
				endcase
				if (st_reg.scan_idx == 3'(CLD_IMG_WORDS - 1)) begin
					st_next.state = CLD_S_DONE;
					st_next.loaded = 1'b1;
					ev[CLD_IRQ_LOAD] = 1'b1;
				end else begin
					st_next.scan_idx = st_reg.scan_idx + 3'h1;
				end
			end
			CLD_S_DONE: begin
				st_next.state = CLD_S_DONE;
			end
			default: st_next.state = CLD_S_IDLE;
		endcase
		// Bus reset or software reload forces a fresh scan
		if (usb_bus_reset || st_reg.reload_req) begin
			st_next.state = CLD_S_IDLE;
			st_next.loaded = 1'b0;
			st_next.reload_req = 1'b0;
		end

		// Remote wake: low wake pin, enabled, while suspended
		if (st_reg.wake_on) begin
			if (st_reg.wake_cnt == 32'(CLD_WAKE_CYC - 1)) begin
				st_next.wake_on = 1'b0;
				ev[CLD_IRQ_WAKE] = 1'b1;
			end else begin
				st_next.wake_cnt = st_reg.wake_cnt + 32'h1;
			end
		end else if (!wake_n_sync && st_reg.opts[CLD_OPT_WAKE_BIT] && suspended
			&& st_reg.loaded) begin
			st_next.wake_on = 1'b1;
			st_next.wake_cnt = 32'h0;
		end

		// Rising charger detect is an event
		st_next.chg_prev = chg_det;
		if (chg_det && !st_reg.chg_prev) begin
			ev[CLD_IRQ_CHG] = 1'b1;
		end

		// AXI write channels taken in either order
		if (aw_fire) begin
			st_next.aw_held = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (w_fire) begin
			st_next.w_held = 1'b1;
			st_next.w_data = s_axi_wdata;
		end
		if (wr_go) begin
			st_next.aw_held = 1'b0;
			st_next.w_held = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = 2'b00;
			case (st_reg.aw_addr)
				CLD_CTRL_OFF: st_next.reload_req = st_reg.w_data[0];
				CLD_IRQ_CLR_OFF: st_next.irq_stat = st_reg.irq_stat & ~st_reg.w_data[CLD_IRQ_W-1:0];
				CLD_IRQ_EN_OFF: st_next.irq_en = st_reg.w_data[CLD_IRQ_W-1:0];
				CLD_IMG_ADDR_OFF: st_next.wr_addr = st_reg.w_data[2:0];
				CLD_IMG_DATA_OFF: st_next.wr_addr = st_reg.wr_addr + 3'h1;
				CLD_STAT_OFF, CLD_IRQ_STAT_OFF: ;
				default: st_next.bresp = 2'b10;
			endcase
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end

		// Events set after clear so a set in the clear cycle wins
		st_next.irq_stat = st_next.irq_stat | ev;

		// AXI read
		if (ar_fire) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = 2'b00;
			case (s_axi_araddr)
				CLD_CTRL_OFF: st_next.rdata = {31'h0, st_reg.reload_req};
				CLD_STAT_OFF: st_next.rdata = {st_reg.usbver, 6'h0, st_reg.wake_on, chg_det,
					suspended, st_reg.fn6, st_reg.fn5, st_reg.loaded};
				CLD_IRQ_STAT_OFF: st_next.rdata = {29'h0, st_reg.irq_stat};
				CLD_IRQ_EN_OFF: st_next.rdata = {29'h0, st_reg.irq_en};
				CLD_IMG_ADDR_OFF: st_next.rdata = {29'h0, st_reg.wr_addr};
				CLD_IRQ_CLR_OFF, CLD_IMG_DATA_OFF: st_next.rdata = 32'h0;
				default: begin
					st_next.rdata = 32'h0;
					st_next.rresp = 2'b10;
				end
			endcase
		end else if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '{state: CLD_S_IDLE, opts: CLD_OPTS_RST, fn5: CLD_FN_PIN5_RST,
				fn6: CLD_FN_PIN6_RST, usbver: CLD_USBVER_RST, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign s_axi_awready = !st_reg.aw_held;
	assign s_axi_wready = !st_reg.w_held;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign irq = |(st_reg.irq_stat & st_reg.irq_en);
	assign usb_wake_signal = st_reg.wake_on;
	assign usb_version = st_reg.usbver;
	assign power_enable_n = suspended || !st_reg.loaded;

	// Pull-down only when enabled and suspend shown by the power enable pin
	assign fifo_pulldown_oe = st_reg.loaded && st_reg.opts[CLD_OPT_PD_BIT] && power_enable_n;

	// Per pin function decode; until loaded all pins float
	logic [2:0] fn_pin [2];
	assign fn_pin[0] = st_reg.fn5;
	assign fn_pin[1] = st_reg.fn6;
	logic [1:0] sense_hit, awake_hit;
	for (genvar p = 0; p < 2; p++) begin : g_pin
		assign config_io_pins_oe[p] = st_reg.loaded && cld_is_chg(fn_pin[p]);
		assign config_io_pins_out[p] = (fn_pin[p] == CLD_FN_CHG_N) ? !chg_det : chg_det;
		assign sense_hit[p] = st_reg.loaded && (fn_pin[p] == CLD_FN_HOST_SENSE) && pins_sync[p];
		assign awake_hit[p] = st_reg.loaded && (fn_pin[p] == CLD_FN_STAY_AWAKE) && !pins_sync[p];
	end
	assign usb_host_power = |sense_hit;
	assign usb_stay_awake = |awake_hit;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking testbench for the configuration loader block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cld_pkg::*;
	logic clk, arst_n, awv, wv, bre, arv, rre, brst, wk_n, awr, wrd, bvl, arr, rvl;
	logic sus, shrt, brs, wsig, stay, hpow, pen_n, pd, irq;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd, rv;
	logic [1:0] mode, pin_in, pin_out, pin_oe, br, rr;
	logic [15:0] ver;
	int err_total, n_checks, cyc;
	cld_top cld_top_inst (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bvl), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rvl), .s_axi_rready(rre), .usb_bus_reset(brs),
		.usb_suspend(sus), .usb_lines_shorted(shrt), .usb_wake_signal(wsig),
		.usb_stay_awake(stay), .usb_host_power(hpow), .usb_version(ver), .wake_request_n(wk_n),
		.power_enable_n(pen_n), .config_io_pins_in(pin_in), .config_io_pins_out(pin_out),
		.config_io_pins_oe(pin_oe), .fifo_pulldown_oe(pd), .irq(irq));
	cld_host_mdl cld_host_mdl_inst (.clk(clk), .arst_n(arst_n), .mode(mode),
		.bus_rst_req(brst), .usb_suspend(sus), .usb_lines_shorted(shrt), .usb_bus_reset(brs));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Write: both halves offered together, each dropped once taken
	// Slave outputs are read at the falling edge, where they already stand for the next rise
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ad, dd, ta, td, got;
		logic [1:0] resp;
		ad = 1'b0;
		dd = 1'b0;
		got = 1'b0;
		resp = 2'b00;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		while (!(ad && dd)) begin
			@(negedge clk);
			ta = !ad && awr;
			td = !dd && wrd;
			@(posedge clk);
			if (ta) begin
				ad = 1'b1;
				awv <= 1'b0;
			end
			if (td) begin
				dd = 1'b1;
				wv <= 1'b0;
			end
		end
		while (!got) begin
			@(negedge clk);
			got = bvl;
			resp = br;
			@(posedge clk);
		end
		bre <= 1'b0;
		chk("bresp", er, resp);
		// Idle edge so the next call never reassigns in this step
		@(posedge clk);
	endtask
	task automatic axr(input logic [7:0] a, input logic [1:0] er);
		logic got;
		logic [1:0] resp;
		got = 1'b0;
		resp = 2'b00;
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		while (!got) begin
			@(negedge clk);
			got = arr;
			@(posedge clk);
		end
		arv <= 1'b0;
		got = 1'b0;
		while (!got) begin
			@(negedge clk);
			got = rvl;
			rv = rd;
			resp = rr;
			@(posedge clk);
		end
		rre <= 1'b0;
		chk("rresp", er, resp);
		@(posedge clk);
	endtask
	// Request a reload from the image when go is set, then poll until loaded
	task automatic reload(input logic go);
		if (go) axw(CLD_CTRL_OFF, 32'h1, 2'b00);
		repeat (2) @(posedge clk);
		do axr(CLD_STAT_OFF, 2'b00); while (!rv[0]);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// ****************************************
	// Clock, timeout and main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Whole run needs a few hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	initial begin
		{arst_n, awv, wv, bre, arv, rre, brst} = 7'h0;
		{awa, ara, wd, mode, cyc, err_total, n_checks} = '0;
		wk_n = 1'b1;
		pin_in = 2'b01;
		settle(5);
		chk("oe in reset", 2'b00, pin_oe);
		settle(5);
		arst_n <= 1'b1;
		settle(1);
		chk("oe before load", 2'b00, pin_oe);
		reload(1'b0);
		chk("fn5", CLD_FN_PIN5_RST, rv[3:1]);
		chk("fn6", CLD_FN_PIN6_RST, rv[6:4]);
		chk("ver", CLD_USBVER_RST, rv[31:16]);
		chk("ver port", CLD_USBVER_RST, ver);
		chk("host power", 1, hpow);
		chk("stay awake", 1, stay);
		pin_in <= 2'b10;
		settle(4);
		chk("host power", 0, hpow);
		chk("stay awake", 0, stay);
		mode <= 2'd1;
		settle(4);
		chk("pd default", 0, pd);
		chk("power enable", 1, pen_n);
		axw(CLD_IMG_ADDR_OFF, 32'h0, 2'b00);
		axw(CLD_IMG_DATA_OFF, 32'h1, 2'b00);
		axw(CLD_IMG_DATA_OFF, 32'(CLD_FN_CHG), 2'b00);
		axw(CLD_IMG_DATA_OFF, 32'(CLD_FN_CHG_N), 2'b00);
		chk("pd before reload", 0, pd);
		reload(1'b1);
		chk("pd suspended", 1, pd);
		axw(CLD_IRQ_EN_OFF, 32'h2, 2'b00);
		axw(CLD_IRQ_CLR_OFF, 32'h7, 2'b00);
		mode <= 2'd0;
		settle(4);
		chk("pd awake", 0, pd);
		chk("oe", 2'b11, pin_oe);
		chk("chg host", 2'b10, pin_out);
		chk("irq idle", 0, irq);
		mode <= 2'd2;
		settle(4);
		chk("chg port", 2'b01, pin_out);
		chk("irq raised", 1, irq);
		axw(CLD_IRQ_CLR_OFF, 32'h2, 2'b00);
		chk("irq cleared", 0, irq);
		axw(CLD_IRQ_EN_OFF, 32'h0, 2'b00);
		mode <= 2'd0;
		settle(4);
		mode <= 2'd2;
		settle(4);
		chk("irq masked", 0, irq);
		axr(CLD_IRQ_STAT_OFF, 2'b00);
		chk("irq stat", 1, rv[1]);
		brst <= 1'b1;
		settle(4);
		chk("oe bus reset", 2'b00, pin_oe);
		brst <= 1'b0;
		reload(1'b0);
		chk("oe reloaded", 2'b11, pin_oe);
		axw(8'h1c, 32'h0, 2'b10);
		axr(8'h1c, 2'b10);
		chk("rdata unmapped", 0, rv);
		mode <= 2'd1;
		wk_n <= 1'b0;
		settle(20);
		chk("wake disabled", 0, wsig);
		wk_n <= 1'b1;
		axw(CLD_IMG_ADDR_OFF, 32'h0, 2'b00);
		axw(CLD_IMG_DATA_OFF, 32'h2, 2'b00);
		reload(1'b1);
		wk_n <= 1'b0;
		for (int i = 0; i < 20 && wsig !== 1'b1; i++) @(posedge clk);
		settle(10);
		chk("wake sent", 1, wsig);
		print_verdict();
	end
endmodule
`default_nettype wire
